// ### rdsc_top.v
// The implementer's own choices: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "rdsc_map.vh"

module rdsc_top #(
	parameter [31:0] FLASH_CYC = `RDSC_FLASH_MS * `RDSC_CLK_KHZ
) (
	input wire REF_CLK,
	input wire RST,
	input wire CE,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	output reg [31:0] PRDATA,
	output reg PREADY,
	output reg PSLVERR,
	input wire RXD,
	output reg TXD,
	output reg TX_EN,
	input wire BTN_MENU,
	input wire BTN_UP,
	input wire BTN_ENTER,
	input wire BTN_PEAK,
	input wire BTN_VALLEY,
	input wire BTN_PROC,
	output reg [1:0] COLOUR,
	output reg DISP_BLANK,
	output reg DISP_PEAK,
	output reg DISP_STORE
);
	localparam M_RUN = 2'h0, M_TOP = 2'h1, M_SUB = 2'h2;
	localparam R_IDLE = 2'h0, R_START = 2'h1, R_DATA = 2'h2, R_STOP = 2'h3;
	localparam F_STAR = 3'h0, F_TENS = 3'h1, F_UNITS = 3'h2, F_CR1 = 3'h3, F_DATA = 3'h4;

	// Alarm test against the high limit, the low limit or both, by mode
	function alarm_hit;
		input signed [15:0] val;
		input signed [15:0] lo;
		input signed [15:0] hi;
		input [1:0] mode;
		begin
			case (mode)
				`RDSC_AMODE_HIGH: alarm_hit = (val >= hi);
				`RDSC_AMODE_LOW: alarm_hit = (val <= lo);
				`RDSC_AMODE_WIN: alarm_hit = (val <= lo) || (val >= hi);
				default: alarm_hit = 1'b0;
			endcase
		end
	endfunction

	// Letters and punctuation without a glyph become blanks
	function [7:0] glyph;
		input [7:0] c;
		begin
			case (c | 8'h20)
				8'h78, 8'h77, 8'h7A: glyph = `RDSC_CH_SPACE;
				default: glyph = ((c < 8'h20) || (c == 8'h21) || (c == 8'h22) || (c == 8'h3B) ||
					(c == 8'h3F) || (c > 8'h7E)) ? `RDSC_CH_SPACE : c;
			endcase
		end
	endfunction

	// Pin synchronisers, second stage feeds the logic
	reg [6:0] pin_s1_reg;
	reg [6:0] pin_s2_reg;
	reg [6:0] pin_old_reg;
	wire [6:0] pin_in = {RXD, BTN_PROC, BTN_VALLEY, BTN_PEAK, BTN_ENTER, BTN_UP, BTN_MENU};
	wire [5:0] press = pin_s2_reg[5:0] & ~pin_old_reg[5:0];
	wire rx_pin = pin_s2_reg[6];
	always @(posedge REF_CLK) begin
		if (RST) begin
			pin_s1_reg <= 7'h40;
			pin_s2_reg <= 7'h40;
			pin_old_reg <= 7'h40;
		end else if (CE) begin
			pin_s1_reg <= pin_in;
			pin_s2_reg <= pin_s1_reg;
			pin_old_reg <= pin_s2_reg;
		end
	end

	// Software registers
	reg [15:0] ctrl_reg;
	reg [15:0] baud_reg;
	reg [15:0] value_reg;
	reg [5:0] al1_reg;
	reg [5:0] al2_reg;
	reg [31:0] lim1_reg;
	reg [31:0] lim2_reg;
	reg [1:0] ncol_reg;
	reg [47:0] disp_reg;
	reg [7:0] param_reg [0:3];
	wire host = ctrl_reg[`RDSC_CTRL_HOST];
	wire multi = ctrl_reg[`RDSC_CTRL_MULTI];
	wire ptype = ctrl_reg[`RDSC_CTRL_PTYPE];
	wire [7:0] addr_bcd = ctrl_reg[15:8];

	// Alarm and colour choice, alarm 1 first
	wire a1 = al1_reg[0] & alarm_hit(value_reg, lim1_reg[15:0], lim1_reg[31:16], al1_reg[2:1]);
	wire a2 = al2_reg[0] & alarm_hit(value_reg, lim2_reg[15:0], lim2_reg[31:16], al2_reg[2:1]);
	wire [1:0] colour_next = a1 ? al1_reg[5:4] : (a2 ? al2_reg[5:4] : ncol_reg);

	// Transmitter state
	reg [39:0] tx_buf_reg;
	reg [2:0] tx_len_reg;
	reg [2:0] tx_idx_reg;
	reg [9:0] tx_sh_reg;
	reg [3:0] tx_bit_reg;
	reg [15:0] tx_cnt_reg;
	reg tx_busy_reg;

	// Receiver and frame parser state
	reg [1:0] rx_st_reg;
	reg [15:0] rx_cnt_reg;
	reg [2:0] rx_bit_reg;
	reg [7:0] rx_sh_reg;
	reg [2:0] fr_st_reg;
	reg [3:0] fr_tens_reg;
	reg fr_match_reg;
	reg [2:0] fr_len_reg;
	reg [47:0] fr_buf_reg;
	reg [7:0] frames_reg;
	reg fr_mode_reg;

	// Menu state
	reg [1:0] menu_st_reg;
	reg [1:0] item_reg;
	reg [7:0] work_reg;
	reg [31:0] fl_cnt_reg;
	reg [3:0] fl_halves_reg;
	reg fl_peak_reg;

	// APB slave: answers in the first access cycle
	wire apb_wr = PSEL & PENABLE & PREADY & PWRITE;
	wire setup = PSEL & ~PENABLE;
	reg [31:0] rd_mux;
	reg hit;
	always @* begin
		hit = 1'b1;
		case (PADDR)
			`RDSC_OFS_CTRL: rd_mux = {16'h0000, ctrl_reg};
			`RDSC_OFS_BAUD: rd_mux = {16'h0000, baud_reg};
			`RDSC_OFS_VALUE: rd_mux = {16'h0000, value_reg};
			`RDSC_OFS_AL1: rd_mux = {26'h0000000, al1_reg};
			`RDSC_OFS_LIM1: rd_mux = lim1_reg;
			`RDSC_OFS_AL2: rd_mux = {26'h0000000, al2_reg};
			`RDSC_OFS_LIM2: rd_mux = lim2_reg;
			`RDSC_OFS_NCOL: rd_mux = {30'h00000000, ncol_reg};
			`RDSC_OFS_DISPLO: rd_mux = disp_reg[31:0];
			`RDSC_OFS_DISPHI: rd_mux = {16'h0000, disp_reg[47:32]};
			`RDSC_OFS_STATUS: rd_mux = {frames_reg, param_reg[item_reg], 6'h00, tx_busy_reg, a2, a1,
				fl_peak_reg, item_reg, menu_st_reg, COLOUR};
			default: begin
				rd_mux = 32'h00000000;
				hit = 1'b0;
			end
		endcase
	end

	always @(posedge REF_CLK) begin
		if (RST) begin
			PREADY <= 1'b0;
			PRDATA <= 32'h00000000;
			PSLVERR <= 1'b0;
			ctrl_reg <= `RDSC_CTRL_RST;
			baud_reg <= `RDSC_BAUD_RST;
			value_reg <= 16'h0000;
			al1_reg <= 6'h00;
			al2_reg <= 6'h00;
			lim1_reg <= 32'h00000000;
			lim2_reg <= 32'h00000000;
			ncol_reg <= `RDSC_COL_GREEN;
		end else if (CE) begin
			PREADY <= setup;
			PSLVERR <= setup & ~hit;
			if (setup)
				PRDATA <= PWRITE ? 32'h00000000 : rd_mux;
			if (apb_wr && hit) begin
				case (PADDR)
					`RDSC_OFS_CTRL: ctrl_reg <= PWDATA[15:0];
					`RDSC_OFS_BAUD: baud_reg <= PWDATA[15:0];
					`RDSC_OFS_VALUE: value_reg <= PWDATA[15:0];
					`RDSC_OFS_AL1: al1_reg <= PWDATA[5:0];
					`RDSC_OFS_LIM1: lim1_reg <= PWDATA;
					`RDSC_OFS_AL2: al2_reg <= PWDATA[5:0];
					`RDSC_OFS_LIM2: lim2_reg <= PWDATA;
					`RDSC_OFS_NCOL: ncol_reg <= PWDATA[1:0];
					default: ;
				endcase
			end
		end
	end

	// Host requests: command digit chosen by button, and by peer type for peak and valley (proc is always '1')
	wire [7:0] cmd_dig = press[3] ? (ptype ? 8'h33 : 8'h32) :
		press[4] ? (ptype ? 8'h34 : 8'h33) : 8'h31;
	wire [7:0] a_tens = {4'h3, addr_bcd[7:4]};
	wire [7:0] a_units = {4'h3, addr_bcd[3:0]};
	wire req = host & ~tx_busy_reg & (|press[5:3]);

	// Transmitter, 8N1; driver enable only while sending on the shared pair
	always @(posedge REF_CLK) begin
		if (RST) begin
			tx_busy_reg <= 1'b0;
			tx_buf_reg <= 40'h0000000000;
			tx_len_reg <= 3'h0;
			tx_idx_reg <= 3'h0;
			tx_sh_reg <= 10'h3FF;
			tx_bit_reg <= 4'h0;
			tx_cnt_reg <= 16'h0000;
			TXD <= 1'b1;
			TX_EN <= 1'b0;
		end else if (CE) begin
			TX_EN <= ~multi | tx_busy_reg;
			TXD <= tx_sh_reg[0];
			if (req) begin
				tx_busy_reg <= 1'b1;
				tx_idx_reg <= 3'h0;
				tx_bit_reg <= 4'h0;
				tx_cnt_reg <= 16'h0000;
				if (multi) begin
					tx_buf_reg <= {cmd_dig, `RDSC_CH_ZERO, `RDSC_CH_X, a_units, a_tens};
					tx_len_reg <= 3'h5;
				end else begin
					tx_buf_reg <= {16'h0000, cmd_dig, `RDSC_CH_ZERO, `RDSC_CH_X};
					tx_len_reg <= 3'h3;
				end
				tx_sh_reg <= {1'b1, `RDSC_CH_STAR, 1'b0};
			end else if (tx_busy_reg) begin
				if (tx_cnt_reg == baud_reg) begin
					tx_cnt_reg <= 16'h0000;
					tx_sh_reg <= {1'b1, tx_sh_reg[9:1]};
					if (tx_bit_reg == 4'h9) begin
						tx_bit_reg <= 4'h0;
						if (tx_idx_reg == tx_len_reg) begin
							tx_busy_reg <= 1'b0;
						end else begin
							tx_sh_reg <= {1'b1, tx_buf_reg[7:0], 1'b0};
							tx_buf_reg <= {8'h00, tx_buf_reg[39:8]};
							tx_idx_reg <= tx_idx_reg + 3'h1;
						end
					end else begin
						tx_bit_reg <= tx_bit_reg + 4'h1;
					end
				end else begin
					tx_cnt_reg <= tx_cnt_reg + 16'h0001;
				end
			end
		end
	end

	// Receiver; on the half-duplex pair our own echo is ignored
	wire rx_ok = ~(multi & tx_busy_reg);
	wire [15:0] half_baud = {1'b0, baud_reg[15:1]};
	reg rx_stb;
	always @(posedge REF_CLK) begin
		if (RST) begin
			rx_st_reg <= R_IDLE;
			rx_cnt_reg <= 16'h0000;
			rx_bit_reg <= 3'h0;
			rx_sh_reg <= 8'h00;
			rx_stb <= 1'b0;
		end else if (CE) begin
			rx_stb <= 1'b0;
			rx_cnt_reg <= rx_cnt_reg + 16'h0001;
			case (rx_st_reg)
				R_IDLE: begin
					rx_cnt_reg <= 16'h0000;
					if (!rx_pin && rx_ok)
						rx_st_reg <= R_START;
				end
				R_START: if (rx_cnt_reg == half_baud) begin
					rx_cnt_reg <= 16'h0000;
					rx_bit_reg <= 3'h0;
					rx_st_reg <= rx_pin ? R_IDLE : R_DATA;
				end
				R_DATA: if (rx_cnt_reg == baud_reg) begin
					rx_cnt_reg <= 16'h0000;
					rx_sh_reg <= {rx_pin, rx_sh_reg[7:1]};
					rx_bit_reg <= rx_bit_reg + 3'h1;
					if (rx_bit_reg == 3'h7)
						rx_st_reg <= R_STOP;
				end
				R_STOP: if (rx_cnt_reg == baud_reg) begin
					rx_st_reg <= R_IDLE;
					rx_stb <= rx_pin;
				end
				default: rx_st_reg <= R_IDLE;
			endcase
		end
	end

	// Slave-mode frame parser; a frame of the wrong length is dropped
	wire [2:0] fr_home = multi ? F_STAR : F_DATA;
	wire is_cr = (rx_sh_reg == `RDSC_CH_CR);
	always @(posedge REF_CLK) begin
		if (RST) begin
			fr_st_reg <= F_DATA;
			fr_tens_reg <= 4'h0;
			fr_match_reg <= 1'b0;
			fr_len_reg <= 3'h0;
			fr_buf_reg <= 48'h000000000000;
			disp_reg <= {6{`RDSC_CH_SPACE}};
			frames_reg <= 8'h00;
			fr_mode_reg <= 1'b0;
		end else if (CE) begin
			// A change of link mode restarts the parser, so no stale state of the old mode survives
			fr_mode_reg <= multi;
			if (host || fr_mode_reg != multi) begin
				fr_st_reg <= fr_home;
				fr_len_reg <= 3'h0;
			end else if (rx_stb) begin
				case (fr_st_reg)
					F_STAR: if (rx_sh_reg == `RDSC_CH_STAR)
						fr_st_reg <= F_TENS;
					F_TENS: begin
						fr_tens_reg <= rx_sh_reg[3:0];
						fr_st_reg <= F_UNITS;
					end
					F_UNITS: begin
						fr_match_reg <= ({fr_tens_reg, rx_sh_reg[3:0]} == addr_bcd);
						fr_st_reg <= F_CR1;
					end
					F_CR1: fr_st_reg <= is_cr ? F_DATA : F_STAR;
					F_DATA: begin
						if (is_cr) begin
							if (fr_len_reg == `RDSC_FRAME_LEN && (fr_match_reg || !multi)) begin
								disp_reg <= {glyph(fr_buf_reg[47:40]), glyph(fr_buf_reg[39:32]),
									glyph(fr_buf_reg[31:24]), glyph(fr_buf_reg[23:16]),
									glyph(fr_buf_reg[15:8]), glyph(fr_buf_reg[7:0])};
								frames_reg <= frames_reg + 8'h01;
							end
							fr_len_reg <= 3'h0;
							fr_st_reg <= fr_home;
						end else begin
							fr_buf_reg <= {fr_buf_reg[39:0], rx_sh_reg};
							if (fr_len_reg != 3'h7)
								fr_len_reg <= fr_len_reg + 3'h1;
						end
					end
					default: fr_st_reg <= fr_home;
				endcase
			end
		end
	end

	// Front-panel menu; items 0..1 are choice lists, 2..3 numbers that wrap
	wire fl_tick = (fl_cnt_reg == FLASH_CYC - 32'h1);
	wire [7:0] work_up = (!item_reg[1] && work_reg == `RDSC_SEL_LAST) ? 8'h00 : work_reg + 8'h01;
	always @(posedge REF_CLK) begin
		if (RST) begin
			menu_st_reg <= M_RUN;
			item_reg <= 2'h0;
			work_reg <= 8'h00;
			fl_cnt_reg <= 32'h00000000;
			fl_halves_reg <= 4'h0;
			fl_peak_reg <= 1'b0;
			param_reg[0] <= 8'h00;
			param_reg[1] <= 8'h00;
			param_reg[2] <= 8'h00;
			param_reg[3] <= 8'h00;
		end else if (CE) begin
			if (fl_halves_reg != 4'h0) begin
				fl_cnt_reg <= fl_tick ? 32'h00000000 : fl_cnt_reg + 32'h1;
				if (fl_tick)
					fl_halves_reg <= fl_halves_reg - 4'h1;
			end
			case (menu_st_reg)
				M_RUN: begin
					if (press[0]) begin
						menu_st_reg <= M_TOP;
						item_reg <= 2'h0;
					end else if (press[1] && fl_halves_reg == 4'h0) begin
						fl_peak_reg <= 1'b1;
						fl_halves_reg <= `RDSC_PEAK_HALVES;
						fl_cnt_reg <= 32'h00000000;
					end
				end
				M_TOP: begin
					if (press[0])
						item_reg <= (item_reg == `RDSC_MENU_ITEMS) ? 2'h0 : item_reg + 2'h1;
					else if (press[1])
						menu_st_reg <= M_RUN;
					else if (press[2]) begin
						menu_st_reg <= M_SUB;
						work_reg <= param_reg[item_reg];
					end
				end
				M_SUB: begin
					if (press[0])
						menu_st_reg <= M_TOP;
					else if (press[1])
						work_reg <= work_up;
					else if (press[2]) begin
						param_reg[item_reg] <= work_reg;
						menu_st_reg <= M_TOP;
						fl_peak_reg <= 1'b0;
						fl_halves_reg <= `RDSC_STORE_HALVES;
						fl_cnt_reg <= 32'h00000000;
					end
				end
				default: menu_st_reg <= M_RUN;
			endcase
		end
	end

	// Display outputs; peak shows in odd halves, store message for its whole time
	always @(posedge REF_CLK) begin
		if (RST) begin
			COLOUR <= `RDSC_COL_GREEN;
			DISP_BLANK <= 1'b0;
			DISP_PEAK <= 1'b0;
			DISP_STORE <= 1'b0;
		end else if (CE) begin
			COLOUR <= colour_next;
			DISP_PEAK <= fl_peak_reg && (fl_halves_reg != 4'h0);
			DISP_BLANK <= fl_peak_reg && fl_halves_reg[0];
			DISP_STORE <= !fl_peak_reg && (fl_halves_reg != 4'h0);
		end
	end
endmodule // rdsc_top
`default_nettype wire

// ### rdsc_map.vh
`ifndef RDSC_MAP_VH
`define RDSC_MAP_VH
`define RDSC_OFS_CTRL 12'h000
`define RDSC_OFS_BAUD 12'h004
`define RDSC_OFS_VALUE 12'h008
`define RDSC_OFS_AL1 12'h00C
`define RDSC_OFS_LIM1 12'h010
`define RDSC_OFS_AL2 12'h014
`define RDSC_OFS_LIM2 12'h018
`define RDSC_OFS_NCOL 12'h01C
`define RDSC_OFS_DISPLO 12'h020
`define RDSC_OFS_DISPHI 12'h024
`define RDSC_OFS_STATUS 12'h028
`define RDSC_CTRL_HOST 0
`define RDSC_CTRL_MULTI 1
`define RDSC_CTRL_PTYPE 2
`define RDSC_CTRL_RST 16'h0000
`define RDSC_BAUD_RST 16'h32DD
`define RDSC_COL_GREEN 2'h0
`define RDSC_COL_RED 2'h1
`define RDSC_COL_AMBER 2'h2
`define RDSC_AMODE_HIGH 2'h0
`define RDSC_AMODE_LOW 2'h1
`define RDSC_AMODE_WIN 2'h2
`define RDSC_CH_STAR 8'h2A
`define RDSC_CH_CR 8'h0D
`define RDSC_CH_X 8'h58
`define RDSC_CH_ZERO 8'h30
`define RDSC_CH_SPACE 8'h20
`define RDSC_FRAME_LEN 3'h6
`define RDSC_MENU_ITEMS 2'h3
`define RDSC_SEL_LAST 8'h02
`define RDSC_FLASH_MS 250
`define RDSC_CLK_KHZ 125000
`define RDSC_PEAK_HALVES 4'h6
`define RDSC_STORE_HALVES 4'h2
`endif

// ### rdsc_props.sv
`timescale 1ns/1ns
`default_nettype none
module rdsc_props #(
	parameter [31:0] FLASH_CYC = 32'h8
) (
	input wire REF_CLK,
	input wire RST,
	input wire PSEL,
	input wire PENABLE,
	input wire PWRITE,
	input wire [11:0] PADDR,
	input wire [31:0] PWDATA,
	input wire PREADY,
	input wire PSLVERR,
	input wire TXD,
	input wire TX_EN,
	input wire BTN_PEAK,
	input wire BTN_VALLEY,
	input wire BTN_PROC,
	input wire DISP_BLANK,
	input wire DISP_PEAK,
	input wire DISP_STORE
);
	logic host_reg;
	logic multi_reg;
	logic [7:0] quiet_reg;
	logic [31:0] peak_reg;
	logic [31:0] store_reg;
	default clocking @(posedge REF_CLK); endclocking
	default disable iff (RST);
	// Shadow mode bits and length counters; quiet saturates so a press is judged only when the line is idle
	always @(posedge REF_CLK) begin
		if (RST) begin
			host_reg <= 1'b0;
			multi_reg <= 1'b0;
			quiet_reg <= 8'h00;
			peak_reg <= 32'h0;
			store_reg <= 32'h0;
		end else begin
			if (PSEL && PENABLE && PREADY && PWRITE && PADDR == 12'h000) begin
				host_reg <= PWDATA[0];
				multi_reg <= PWDATA[1];
			end
			quiet_reg <= !TXD ? 8'h00 : (quiet_reg == 8'hFF ? quiet_reg : quiet_reg + 8'h01);
			peak_reg <= DISP_PEAK ? peak_reg + 32'h1 : 32'h0;
			store_reg <= DISP_STORE ? store_reg + 32'h1 : 32'h0;
		end
	end
	a_ready_one_cycle: assert property (PSEL && PENABLE && PREADY |=> !PREADY)
		else $error("pready stood longer than one cycle");
	a_ready_zero_wait: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("pready missing in first access cycle");
	a_err_unmapped: assert property (PSEL && PENABLE && PREADY && PADDR > 12'h028 |-> PSLVERR)
		else $error("unmapped access without slave error");
	a_txen_point: assert property (!$past(RST) && !multi_reg && !$past(multi_reg) && !$past(multi_reg, 2) |-> TX_EN)
		else $error("driver off on full duplex link");
	a_req_start: assert property (host_reg && quiet_reg == 8'hFF && ($rose(BTN_PEAK) || $rose(BTN_VALLEY) || $rose(BTN_PROC)) |-> ##[1:12] !TXD)
		else $error("request start bit late");
	a_blank_in_peak: assert property (DISP_BLANK |-> DISP_PEAK)
		else $error("blank outside peak flash");
	a_peak_length: assert property (!$past(RST) && $fell(DISP_PEAK) |-> peak_reg >= 6 * FLASH_CYC - 1 && peak_reg <= 6 * FLASH_CYC + 1)
		else $error("peak flash length wrong");
	a_store_length: assert property (!$past(RST) && $fell(DISP_STORE) |-> store_reg >= 2 * FLASH_CYC - 1 && store_reg <= 2 * FLASH_CYC + 1)
		else $error("store flash length wrong");
	c_peak: cover property ($rose(DISP_PEAK));
	c_store: cover property ($rose(DISP_STORE));
	c_error: cover property (PSLVERR);
	c_send: cover property ($fell(TXD));
endmodule // rdsc_props
bind rdsc_top rdsc_props #(.FLASH_CYC(FLASH_CYC)) u_rdsc_props (.REF_CLK(REF_CLK), .RST(RST), .PSEL(PSEL),
	.PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.TXD(TXD), .TX_EN(TX_EN), .BTN_PEAK(BTN_PEAK), .BTN_VALLEY(BTN_VALLEY), .BTN_PROC(BTN_PROC),
	.DISP_BLANK(DISP_BLANK), .DISP_PEAK(DISP_PEAK), .DISP_STORE(DISP_STORE));
`default_nettype wire

// ### rdsc_peer.sv
`timescale 1ns/1ns
`default_nettype none
module rdsc_peer #(
	parameter int BIT_CYC = 8
) (
	input wire logic clk,
	input wire logic line_in,
	output logic line_out
);
	logic [7:0] got [$];
	logic [7:0] rx_byte;
	// Idle line is mark
	initial line_out = 1'b1;
	// One 8N1 character, LSB first, from the far party
	task automatic send_byte(input logic [7:0] b);
		logic [9:0] f;
		f = {1'b1, b, 1'b0};
		for (int i = 0; i < 10; i++) begin
			@(posedge clk);
			line_out <= f[i];
			repeat (BIT_CYC - 1) @(posedge clk);
		end
	endtask
	// Receiver samples mid-bit so a one-cycle lag of the driver enable is harmless
	always begin
		@(posedge clk);
		if (line_in === 1'b0) begin
			repeat (BIT_CYC / 2) @(posedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (BIT_CYC) @(posedge clk);
				rx_byte[i] = line_in;
			end
			repeat (BIT_CYC) @(posedge clk);
			got.push_back(rx_byte);
		end
	end
endmodule // rdsc_peer
`default_nettype wire

// ### test_remote_display_serial_control.sv
`timescale 1ns/1ns
`default_nettype none
module test_remote_display_serial_control;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0;
	logic [5:0] btn = 6'h00;
	wire [31:0] prdata;
	wire pready, pslverr, txd, tx_en, rxd, disp_blank, disp_peak, disp_store, tx_line;
	wire [1:0] colour;
	int failures = 0;
	int comparisons = 0;
	logic [31:0] rd;
	logic err;
	always #4 ref_clk = ~ref_clk;
	// Pair is biased to mark while the driver is off
	assign tx_line = tx_en ? txd : 1'b1;
	rdsc_top #(.FLASH_CYC(32'h8)) u_rdsc_top (.REF_CLK(ref_clk), .RST(rst), .CE(1'b1), .PSEL(psel),
		.PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready),
		.PSLVERR(pslverr), .RXD(rxd), .TXD(txd), .TX_EN(tx_en), .BTN_MENU(btn[0]), .BTN_UP(btn[1]),
		.BTN_ENTER(btn[2]), .BTN_PEAK(btn[3]), .BTN_VALLEY(btn[4]), .BTN_PROC(btn[5]), .COLOUR(colour),
		.DISP_BLANK(disp_blank), .DISP_PEAK(disp_peak), .DISP_STORE(disp_store));
	rdsc_peer #(.BIT_CYC(8)) u_rdsc_peer (.clk(ref_clk), .line_in(tx_line), .line_out(rxd));
	task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask
	// One APB transfer; request held until pready is sampled high
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= wr;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		// Only the watchdog ends a wait that never gets an answer
		do begin
			@(posedge ref_clk);
		end while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic press(input int i);
		@(posedge ref_clk);
		btn[i] <= 1'b1;
		repeat (4) @(posedge ref_clk);
		btn[i] <= 1'b0;
		repeat (6) @(posedge ref_clk);
	endtask
	task automatic send(input string s);
		foreach (s[i]) u_rdsc_peer.send_byte(s[i]);
		repeat (20) @(posedge ref_clk);
	endtask
	task automatic t_regs;
		apb(1'b0, 12'h000, 32'h0);
		check("ctrl reset", 32'h0, rd);
		apb(1'b0, 12'h004, 32'h0);
		check("baud reset", 32'h32DD, rd);
		apb(1'b0, 12'h024, 32'h0);
		check("text reset", 32'h2020, rd);
		apb(1'b1, 12'h030, 32'hFFFF_FFFF);
		check("unmapped error", 32'h1, {31'h0, err});
		apb(1'b1, 12'h004, 32'h7);
	endtask
	// Every request button (peak, valley, proc) in both peer types, point-to-point and multidrop (address 23)
	task automatic t_host;
		logic [7:0] exp [$];
		logic [7:0] dig;
		int n;
		for (int m = 0; m < 4; m++) begin
			apb(1'b1, 12'h000, {16'h0, 8'h23, 5'h0, m[1], m[0], 1'b1});
			for (int b = 3; b < 6; b++) begin
				dig = (b == 5) ? 8'h31 : 8'h32 + 8'(b - 3 + m[1]);
				exp = {8'h2A};
				if (m[0]) exp = {exp, 8'h32, 8'h33};
				exp = {exp, 8'h58, 8'h30, dig};
				u_rdsc_peer.got.delete();
				press(b);
				n = 0;
				while (u_rdsc_peer.got.size() < exp.size() && n < 2000) begin
					@(posedge ref_clk);
					n++;
				end
				check("request length", 32'(exp.size()), 32'(u_rdsc_peer.got.size()));
				foreach (exp[i]) if (i < u_rdsc_peer.got.size()) check("request char", {24'h0, exp[i]}, {24'h0, u_rdsc_peer.got[i]});
				repeat (300) @(posedge ref_clk);
				check("driver enable idle", {31'h0, !m[0]}, {31'h0, tx_en});
			end
		end
	endtask
	task automatic t_slave;
		apb(1'b1, 12'h000, 32'h0);
		send("Ax1;34\015");
		apb(1'b0, 12'h024, 32'h0);
		check("text high", 32'h4120, rd);
		apb(1'b0, 12'h020, 32'h0);
		check("text low", 32'h3120_3334, rd);
		send("12345\015");
		apb(1'b0, 12'h020, 32'h0);
		check("short frame", 32'h3120_3334, rd);
		apb(1'b1, 12'h000, 32'h2302);
		send("*24\015QQQQQQ\015");
		apb(1'b0, 12'h020, 32'h0);
		check("other address", 32'h3120_3334, rd);
		send("*23\015HELLO9\015");
		apb(1'b0, 12'h024, 32'h0);
		check("own address high", 32'h4845, rd);
		apb(1'b0, 12'h020, 32'h0);
		check("own address low", 32'h4C4C_4F39, rd);
	endtask
	task automatic col(input logic [31:0] v, input logic [1:0] e);
		apb(1'b1, 12'h008, v);
		repeat (4) @(posedge ref_clk);
		check("colour", {30'h0, e}, {30'h0, colour});
	endtask
	task automatic t_colour;
		apb(1'b1, 12'h01C, 32'h0);
		apb(1'b1, 12'h00C, 32'h11);
		apb(1'b1, 12'h010, 32'h0190_0000);
		apb(1'b1, 12'h014, 32'h21);
		apb(1'b1, 12'h018, 32'h00C8_0000);
		col(32'hC7, 2'h0);
		col(32'hC8, 2'h2);
		col(32'h18F, 2'h2);
		col(32'h190, 2'h1);
		apb(1'b1, 12'h00C, 32'h13);
		apb(1'b1, 12'h010, 32'h0190_0064);
		apb(1'b1, 12'h014, 32'h0);
		col(32'h64, 2'h1);
		col(32'h65, 2'h0);
		apb(1'b1, 12'h00C, 32'h15);
		col(32'h190, 2'h1);
		col(32'hFFF6, 2'h1);
		apb(1'b1, 12'h01C, 32'h2);
		col(32'h65, 2'h2);
	endtask
	task automatic t_menu;
		logic [7:0] s0;
		press(0);
		apb(1'b0, 12'h028, 32'h0);
		check("menu state", 32'h1, {30'h0, rd[3:2]});
		s0 = rd[23:16];
		for (int i = 1; i < 5; i++) begin
			press(0);
			apb(1'b0, 12'h028, 32'h0);
			check("menu item", 32'(i % 4), {30'h0, rd[5:4]});
		end
		press(2);
		apb(1'b0, 12'h028, 32'h0);
		check("submenu", 32'h2, {30'h0, rd[3:2]});
		press(1);
		press(0);
		apb(1'b0, 12'h028, 32'h0);
		check("abandon", {24'h0, s0}, {24'h0, rd[23:16]});
		press(2);
		press(1);
		press(2);
		check("store flash", 32'h1, {31'h0, disp_store});
		apb(1'b0, 12'h028, 32'h0);
		check("stored", 32'((s0 + 1) % 3), {24'h0, rd[23:16]});
		press(1);
		apb(1'b0, 12'h028, 32'h0);
		check("run state", 32'h0, {30'h0, rd[3:2]});
		press(1);
		check("peak flash", 32'h1, {31'h0, disp_peak});
		check("peak lit half", 32'h0, {31'h0, disp_blank});
		repeat (8) @(posedge ref_clk);
		check("peak dark half", 32'h1, {31'h0, disp_blank});
		repeat (52) @(posedge ref_clk);
		check("peak over", 32'h0, {31'h0, disp_peak});
	endtask
	task automatic print_verdict;
		$display("comparisons %0d failures %0d", comparisons, failures);
		if (failures == 0 && comparisons > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	initial begin
		repeat (5) @(posedge ref_clk);
		rst <= 1'b0;
		t_regs;
		t_host;
		t_slave;
		t_colour;
		t_menu;
		print_verdict;
	end
	// Watchdog well beyond the expected run of about 12000 cycles
	initial begin
		#600000;
		failures++;
		print_verdict;
	end
endmodule // test_remote_display_serial_control
`default_nettype wire
